/* File: image_pixel_port_tb_top.sv */
`timescale 1ns/1ps
module image_pixel_port_tb_top;
  logic               clk, nrst, tb_hold, enc_full3, dec_valid, dec_last, f3;
  ipp_pkg::ipp_mode_t mode;
  logic [11:0]        dec_data, pixel_o, enc_data;
  logic [3:0]         dec_prec;
  logic [1:0]         dec_comp, component_index;
  logic               pixel_oe, block_sync_n_o, block_sync_n_oe, scan_end_n_o, scan_end_n_oe;
  logic               hold_n_o, hold_n_oe, enc_valid, enc_first, enc_last, dec_ready;
  logic [11:0]        far_pix;
  logic               far_sync, far_eos;
  logic [13:0]        eq [$];
  logic [13:0]        e;
  int                 n_mismatch, samples_checked, kk;
  wire  [11:0]        pix_w  = pixel_oe ? pixel_o : far_pix;
  wire                sync_w = block_sync_n_oe ? block_sync_n_o : far_sync;
  wire                eos_w  = scan_end_n_oe ? scan_end_n_o : far_eos;
  wire                hold_w = hold_n_oe ? hold_n_o : tb_hold;

  ipp_top dut (.clk(clk), .nrst(nrst), .mode(mode), .pixel_i(pix_w), .pixel_o(pixel_o),
    .pixel_oe(pixel_oe), .block_sync_n_i(sync_w), .block_sync_n_o(block_sync_n_o),
    .block_sync_n_oe(block_sync_n_oe), .scan_end_n_i(eos_w), .scan_end_n_o(scan_end_n_o),
    .scan_end_n_oe(scan_end_n_oe), .hold_n_i(hold_w), .hold_n_o(hold_n_o),
    .hold_n_oe(hold_n_oe), .component_index(component_index), .enc_valid(enc_valid),
    .enc_data(enc_data), .enc_first(enc_first), .enc_last(enc_last), .enc_full3(enc_full3),
    .dec_valid(dec_valid), .dec_data(dec_data), .dec_prec(dec_prec), .dec_comp(dec_comp),
    .dec_last(dec_last), .dec_ready(dec_ready));

  ipp_far_model u_far (.clk(clk), .hold_n(hold_w), .pix(far_pix), .sync_n(far_sync),
    .eos_n(far_eos));

  always #5 clk = ~clk;

  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [11:0] fmt(ipp_pkg::ipp_mode_t m, logic [3:0] p, logic [11:0] r);
    int s;
    s = (p == 4'h0 || p > 4'hc) ? 0 : 12 - p;
    if (m == ipp_pkg::MODE_BL_DEC) return {r[7:0], 4'h0};
    if (m == ipp_pkg::MODE_PREVIEW) return {r[10:0], 1'b0};
    return r << s;
  endfunction : fmt

  task automatic set_mode(input ipp_pkg::ipp_mode_t m);
    logic d;
    logic h;
    @(negedge clk);
    mode = m;
    d = m inside {ipp_pkg::MODE_BL_DEC, ipp_pkg::MODE_LL_DEC, ipp_pkg::MODE_PREVIEW};
    h = m inside {ipp_pkg::MODE_BL_ENC, ipp_pkg::MODE_LL_ENC};
    #1;
    chk("pixel_oe", 12'(pixel_oe), 12'(d));
    chk("sync_oe", 12'(block_sync_n_oe), 12'(d));
    chk("hold_oe", 12'(hold_n_oe), 12'(h));
    repeat (2) @(negedge clk);
  endtask : set_mode

  task automatic enc_run(input ipp_pkg::ipp_mode_t m, input int nblk, input int last_len);
    logic [11:0] v;
    logic        bl;
    int          len;
    int          tmo;
    bl = (m == ipp_pkg::MODE_BL_ENC);
    set_mode(m);
    for (int b = 0; b < nblk; b++) begin
      len = (b == nblk - 1) ? last_len : (bl ? 64 : 1);
      for (int k = 0; k < len; k++) begin
        v = 12'($urandom);
        u_far.vals.push_back(v);
        eq.push_back({!bl || k == 0, b == nblk - 1 && k == len - 1, bl ? {v[11:4], 4'h0} : v});
      end
    end
    u_far.send(!bl, nblk, last_len, tmo);
    if (tmo != 0) begin
      n_mismatch++;
      summarize();
    end
    repeat (3) @(negedge clk);
    chk("enc_count", 12'(eq.size()), 12'h000);
    set_mode(ipp_pkg::MODE_IDLE);
  endtask : enc_run

  always @(negedge clk) begin
    if (enc_valid === 1'b1) begin
      if (eq.size() == 0) begin
        chk("enc_extra", 12'h001, 12'h000);
      end else begin
        e = eq.pop_front();
        chk("enc_data", enc_data, e[11:0]);
        chk("enc_first", 12'(enc_first), 12'(e[13]));
        chk("enc_last", 12'(enc_last), 12'(e[12]));
        kk = e[13] ? 0 : kk + 1;
        if (mode == ipp_pkg::MODE_BL_ENC && kk == 19) begin
          chk("hold_n_o", 12'(hold_n_o), 12'h001);
          f3 = enc_full3;
        end
        if (mode == ipp_pkg::MODE_BL_ENC && kk == 20)
          chk("hold_n_o", 12'(hold_n_o), 12'(!f3));
      end
    end
  end

  task automatic dec_run(input ipp_pkg::ipp_mode_t m, input int n, input logic [3:0] p,
                         input int hold_at);
    int          i, cyc, rel;
    logic        tk, pv, pl, bl, fs;
    logic [11:0] pd;
    bl = (m == ipp_pkg::MODE_BL_DEC);
    set_mode(m);
    i = 0;
    cyc = 0;
    rel = -1;
    tk = 1'b0;
    pv = 1'b0;
    pl = 1'b0;
    dec_prec = p;
    dec_data = 12'($urandom);
    dec_comp = 2'($urandom);
    dec_last = (n == 1);
    dec_valid = 1'b1;
    while (i < n || pv) begin
      @(negedge clk);
      cyc++;
      if (cyc > 5000) begin
        n_mismatch++;
        summarize();
      end
      if (pv) chk("pixel_o", pixel_o, pd);
      chk("scan_end_n_o", 12'(scan_end_n_o), 12'(!(pv && pl)));
      pv = 1'b0;
      if (tk) begin
        i++;
        dec_data = 12'($urandom);
        dec_last = (i == n - 1);
        if (!bl || i % 64 == 0) dec_comp = 2'($urandom);
        dec_valid = (i < n);
      end
      if (bl && i == hold_at) tb_hold = 1'b0;
      if (bl && i == 64 && tb_hold == 1'b0) begin
        tb_hold = 1'b1;
        rel = cyc;
      end
      #1;
      tk = (i < n) && dec_ready === 1'b1;
      fs = tk && (!bl || i % 64 == 0);
      chk("block_sync_n_o", 12'(block_sync_n_o), 12'(!fs));
      if (fs) chk("component_index", 12'(component_index), 12'(dec_comp));
      if (fs && rel > 0) begin
        chk("resume_gap", 12'(cyc - rel >= 17), 12'h001);
        rel = -1;
      end
      if (tk) begin
        pv = 1'b1;
        pd = fmt(m, p, dec_data);
        pl = dec_last;
      end
    end
    set_mode(ipp_pkg::MODE_IDLE);
  endtask : dec_run

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    mode = ipp_pkg::MODE_IDLE;
    tb_hold = 1'b1;
    enc_full3 = 1'b0;
    dec_valid = 1'b0;
    dec_data = 12'h000;
    dec_prec = 4'h0;
    dec_comp = 2'h0;
    dec_last = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    kk = 0;
    f3 = 1'b0;
    void'($urandom(11898));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    set_mode(ipp_pkg::MODE_IDLE);
    enc_full3 = 1'b1;
    fork
      enc_run(ipp_pkg::MODE_BL_ENC, 2, 10);
      begin
        for (int w = 0; w < 200 && hold_n_o !== 1'b0; w++) @(negedge clk);
        if (hold_n_o !== 1'b0) begin
          n_mismatch++;
          summarize();
        end
        repeat (50) @(negedge clk);
        enc_full3 = 1'b0;
      end
    join
    enc_run(ipp_pkg::MODE_BL_ENC, 2, 64);
    enc_run(ipp_pkg::MODE_LL_ENC, 5, 1);
    dec_run(ipp_pkg::MODE_BL_DEC, 128, 4'h0, 30);
    dec_run(ipp_pkg::MODE_LL_DEC, 4, 4'h1, -1);
    dec_run(ipp_pkg::MODE_LL_DEC, 4, 4'hc, -1);
    dec_run(ipp_pkg::MODE_LL_DEC, 4, 4'h8, -1);
    dec_run(ipp_pkg::MODE_LL_DEC, 4, 4'h0, -1);
    dec_run(ipp_pkg::MODE_LL_DEC, 4, 4'(1 + $urandom % 12), -1);
    dec_run(ipp_pkg::MODE_PREVIEW, 6, 4'h0, -1);
    summarize();
  end
endmodule : image_pixel_port_tb_top

/* File: ipp_dec_fmt.sv */
`timescale 1ns/1ps
module ipp_dec_fmt (
  input  wire ipp_pkg::ipp_mode_t        mode,
  input  wire logic [3:0]                prec,
  input  wire logic [ipp_pkg::PIX_W-1:0] raw,
  output wire logic [ipp_pkg::PIX_W-1:0] word
);

  // Shift that left-justifies a sample of the given precision
  function automatic logic [3:0] ipp_just(input logic [3:0] p);
    logic [3:0] s;
    s = 4'h0;
    if (p != 4'h0 && p <= 4'hc) begin
      s = 4'hc - p;
    end
    return s;
  endfunction : ipp_just

  wire [3:0]                sh      = ipp_just(prec);
  wire [ipp_pkg::PIX_W-1:0] ll_word = raw << sh;
  wire [ipp_pkg::PIX_W-1:0] bl_word = {raw[ipp_pkg::BL_W-1:0], 4'h0};
  wire [ipp_pkg::PIX_W-1:0] pv_word = {raw[ipp_pkg::PV_W-1:0], 1'b0};

  assign word = (mode == ipp_pkg::MODE_PREVIEW) ? pv_word :
                (mode == ipp_pkg::MODE_LL_DEC)  ? ll_word : bl_word;

endmodule : ipp_dec_fmt

/* File: ipp_enc_rx.sv */
`timescale 1ns/1ps
module ipp_enc_rx (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire ipp_pkg::ipp_mode_t        mode,
  input  wire logic [ipp_pkg::PIX_W-1:0] pixel_i,
  input  wire logic                      sync_n_i,
  input  wire logic                      eos_n_i,
  ipp_smp_if.src                         smp
);

  logic                      act_r;
  logic                      act_nxt;
  logic [ipp_pkg::CNT_W-1:0] cnt_r;
  logic [ipp_pkg::CNT_W-1:0] cnt_nxt;
  logic                      vld_r;
  logic [ipp_pkg::PIX_W-1:0] dat_r;
  logic                      fst_r;
  logic                      lst_r;
  logic [ipp_pkg::CNT_W-1:0] idx_r;

  wire is_bl  = (mode == ipp_pkg::MODE_BL_ENC);
  wire is_enc = is_bl || (mode == ipp_pkg::MODE_LL_ENC);
  wire start  = is_enc && !sync_n_i;
  wire done   = act_r && (!is_bl || cnt_r == ipp_pkg::LAST_IDX || !eos_n_i);

  // Low nibble ignored in baseline; full width in lossless
  wire [ipp_pkg::PIX_W-1:0] word = is_bl ? {pixel_i[ipp_pkg::PIX_W-1 -: ipp_pkg::BL_W], 4'h0}
                                         : pixel_i;

  // Sync restarts count even on the last sample cycle
  assign act_nxt = start ? 1'b1 : (done || !is_enc) ? 1'b0 : act_r;
  assign cnt_nxt = start ? '0 : act_r ? cnt_r + 6'h01 : cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= 1'b0;
      cnt_r <= '0;
      vld_r <= 1'b0;
      dat_r <= ipp_pkg::PIX_RST;
      fst_r <= 1'b0;
      lst_r <= 1'b0;
      idx_r <= '0;
    end else begin
      act_r <= act_nxt;
      cnt_r <= cnt_nxt;
      vld_r <= act_r && is_enc;
      dat_r <= word;
      fst_r <= act_r && cnt_r == '0;
      lst_r <= act_r && !eos_n_i;
      idx_r <= cnt_r;
    end
  end

  assign smp.valid = vld_r;
  assign smp.data  = dat_r;
  assign smp.first = fst_r;
  assign smp.last  = lst_r;
  assign smp.idx   = idx_r;

endmodule : ipp_enc_rx

/* File: ipp_far_model.sv */
`timescale 1ns/1ps
module ipp_far_model (
  input  wire logic        clk,
  input  wire logic        hold_n,
  output logic [11:0]      pix,
  output logic             sync_n,
  output logic             eos_n
);
  logic [11:0] vals [$];

  initial begin
    pix    = 12'h000;
    sync_n = 1'b1;
    eos_n  = 1'b1;
  end

  // Capture source: samples from vals, next baseline sync overlaps last sample unless held; lossless syncs separately
  task automatic send(input logic ll, input int nblk, input int last_len, output int tmo);
    int len;
    int w;
    tmo = 0;
    for (int b = 0; b < nblk; b++) begin
      len = (b == nblk - 1) ? last_len : (ll ? 1 : 64);
      if (sync_n) begin
        w = 0;
        while (hold_n !== 1'b1 && w < 500) begin
          @(negedge clk);
          pix = 12'h000;
          w++;
        end
        if (w >= 500) tmo = 1;
        @(negedge clk);
        pix    = 12'h000;
        sync_n = 1'b0;
      end
      for (int k = 0; k < len; k++) begin
        @(negedge clk);
        pix    = vals.pop_front();
        eos_n  = !(b == nblk - 1 && k == len - 1);
        sync_n = ll || k != len - 1 || b == nblk - 1 || hold_n !== 1'b1;
      end
    end
    @(negedge clk);
    pix    = 12'h000;
    sync_n = 1'b1;
    eos_n  = 1'b1;
  endtask : send
endmodule : ipp_far_model

/* File: ipp_pkg.sv */
package ipp_pkg;

  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_BL_ENC,
    MODE_LL_ENC,
    MODE_BL_DEC,
    MODE_LL_DEC,
    MODE_PREVIEW
  } ipp_mode_t;

  typedef enum logic [1:0] {
    DS_IDLE,
    DS_DATA,
    DS_WAIT
  } ipp_dst_t;

  localparam int PIX_W = 12;
  localparam int BL_W  = 8;
  localparam int PV_W  = 11;
  localparam int CNT_W = 6;

  localparam int BLK_LEN    = 64;
  localparam int HOLD_LEAD  = 42;
  // Edges from pin sample through the index seen by hold logic to registered hold_r
  localparam int CAP_LAT    = 2;
  localparam int STOP_LAT   = 2;
  localparam int RESUME_MIN = 17;
  localparam int EOS_MAX    = 64;

  localparam logic [CNT_W-1:0] LAST_IDX = CNT_W'(BLK_LEN - 1);
  localparam logic [CNT_W-1:0] HOLD_IDX = CNT_W'(BLK_LEN - 1 - HOLD_LEAD - CAP_LAT);
  localparam logic [4:0]       RSM_LAST = 5'(RESUME_MIN - 1);

  localparam logic [PIX_W-1:0] PIX_RST  = 12'h000;
  localparam logic [1:0]       COMP_IDL = 2'h3;

endpackage : ipp_pkg

/* File: ipp_smp_if.sv */
`timescale 1ns/1ps
interface ipp_smp_if;
  logic                       valid;
  logic [ipp_pkg::PIX_W-1:0]  data;
  logic                       first;
  logic                       last;
  logic [ipp_pkg::CNT_W-1:0]  idx;

  modport src (output valid, output data, output first, output last, output idx);
  modport snk (input valid, input data, input first, input last, input idx);
endinterface : ipp_smp_if

/* File: ipp_top.sv */
`timescale 1ns/1ps
module ipp_top (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire ipp_pkg::ipp_mode_t        mode,
  input  wire logic [ipp_pkg::PIX_W-1:0] pixel_i,
  output wire logic [ipp_pkg::PIX_W-1:0] pixel_o,
  output wire logic                      pixel_oe,
  input  wire logic                      block_sync_n_i,
  output wire logic                      block_sync_n_o,
  output wire logic                      block_sync_n_oe,
  input  wire logic                      scan_end_n_i,
  output wire logic                      scan_end_n_o,
  output wire logic                      scan_end_n_oe,
  input  wire logic                      hold_n_i,
  output wire logic                      hold_n_o,
  output wire logic                      hold_n_oe,
  output wire logic [1:0]                component_index,
  output wire logic                      enc_valid,
  output wire logic [ipp_pkg::PIX_W-1:0] enc_data,
  output wire logic                      enc_first,
  output wire logic                      enc_last,
  input  wire logic                      enc_full3,
  input  wire logic                      dec_valid,
  input  wire logic [ipp_pkg::PIX_W-1:0] dec_data,
  input  wire logic [3:0]                dec_prec,
  input  wire logic [1:0]                dec_comp,
  input  wire logic                      dec_last,
  output logic                           dec_ready
);

  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // Mode decode
  wire is_bl_dec = (mode == ipp_pkg::MODE_BL_DEC);
  wire is_dec    = is_bl_dec || (mode == ipp_pkg::MODE_LL_DEC)
                   || (mode == ipp_pkg::MODE_PREVIEW);
  wire is_bl_enc = (mode == ipp_pkg::MODE_BL_ENC);
  wire is_enc    = is_bl_enc || (mode == ipp_pkg::MODE_LL_ENC);
  wire per_smp   = !is_bl_dec;

  // Encode capture path
  ipp_smp_if enc_if ();

  ipp_enc_rx u_enc_rx (
    .clk      (clk),
    .rst_n    (rst_n),
    .mode     (mode),
    .pixel_i  (pixel_i),
    .sync_n_i (block_sync_n_i),
    .eos_n_i  (scan_end_n_i),
    .smp      (enc_if.src)
  );

  assign enc_valid = enc_if.valid;
  assign enc_data  = enc_if.data;
  assign enc_first = enc_if.first;
  assign enc_last  = enc_if.last;

  // Hold request toward the source during encoding
  logic hold_r;
  logic hold_nxt;
  wire  hold_mark = enc_if.valid && enc_if.idx == ipp_pkg::HOLD_IDX;

  assign hold_nxt = !is_enc ? 1'b0 :
                    !is_bl_enc ? enc_full3 :
                    (hold_mark && enc_full3) ? 1'b1 :
                    !enc_full3 ? 1'b0 : hold_r;

  // Decode hold: baseline checks at block end, others after a short latency
  logic hold_d1_r;
  logic hold_d2_r;
  wire  hold_act = !hold_n_i;
  wire  hold_now = per_smp ? hold_d2_r : hold_act;

  // Decode sequencer
  ipp_pkg::ipp_dst_t          dst_r;
  ipp_pkg::ipp_dst_t          dst_nxt;
  logic [ipp_pkg::CNT_W-1:0]  cnt_r;
  logic [ipp_pkg::CNT_W-1:0]  cnt_nxt;
  logic [4:0]                 rsm_r;
  logic [4:0]                 rsm_nxt;
  logic                       sync_n_r;
  logic                       sync_n_nxt;
  logic                       eos_n_r;
  logic                       eos_n_nxt;
  logic                       ovld_r;
  logic                       ovld_nxt;
  logic [ipp_pkg::PIX_W-1:0]  pix_r;
  logic [ipp_pkg::PIX_W-1:0]  pix_nxt;
  logic [1:0]                 comp_r;
  logic [1:0]                 comp_nxt;
  logic [ipp_pkg::PIX_W-1:0]  fmt_word;

  ipp_dec_fmt u_dec_fmt (
    .mode (mode),
    .prec (dec_prec),
    .raw  (dec_data),
    .word (fmt_word)
  );

  wire blk_last  = cnt_r == (per_smp ? '0 : ipp_pkg::LAST_IDX);
  wire can_start = is_dec && dec_valid && !hold_now && eos_n_r;
  wire take_last = dec_valid && dec_last;

  always_comb begin
    dst_nxt    = dst_r;
    cnt_nxt    = cnt_r;
    rsm_nxt    = rsm_r;
    sync_n_nxt = 1'b1;
    eos_n_nxt  = 1'b1;
    ovld_nxt   = 1'b0;
    pix_nxt    = ipp_pkg::PIX_RST;
    comp_nxt   = comp_r;
    dec_ready  = 1'b0;
    case (dst_r)
      ipp_pkg::DS_IDLE: begin
        if (can_start) begin
          sync_n_nxt = 1'b0;
          comp_nxt   = dec_comp;
          cnt_nxt    = '0;
          dst_nxt    = ipp_pkg::DS_DATA;
        end
      end
      ipp_pkg::DS_DATA: begin
        dec_ready = 1'b1;
        ovld_nxt  = 1'b1;
        pix_nxt   = fmt_word;
        eos_n_nxt = !take_last;
        cnt_nxt   = cnt_r + 6'h01;
        if (take_last) begin
          comp_nxt = ipp_pkg::COMP_IDL;
          dst_nxt  = ipp_pkg::DS_IDLE;
        end else if (blk_last) begin
          rsm_nxt = '0;
          dst_nxt = hold_now ? ipp_pkg::DS_WAIT : ipp_pkg::DS_IDLE;
        end
      end
      ipp_pkg::DS_WAIT: begin
        if (hold_now) begin
          rsm_nxt = '0;
        end else if (per_smp || rsm_r == ipp_pkg::RSM_LAST) begin
          dst_nxt = ipp_pkg::DS_IDLE;
        end else begin
          rsm_nxt = rsm_r + 5'h01;
        end
      end
      default: begin
        dst_nxt = ipp_pkg::DS_IDLE;
      end
    endcase
    if (!is_dec) begin
      dst_nxt    = ipp_pkg::DS_IDLE;
      sync_n_nxt = 1'b1;
      eos_n_nxt  = 1'b1;
      ovld_nxt   = 1'b0;
      dec_ready  = 1'b0;
      comp_nxt   = ipp_pkg::COMP_IDL;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dst_r     <= ipp_pkg::DS_IDLE;
      cnt_r     <= '0;
      rsm_r     <= '0;
      sync_n_r  <= 1'b1;
      eos_n_r   <= 1'b1;
      ovld_r    <= 1'b0;
      pix_r     <= ipp_pkg::PIX_RST;
      comp_r    <= ipp_pkg::COMP_IDL;
      hold_r    <= 1'b0;
      hold_d1_r <= 1'b0;
      hold_d2_r <= 1'b0;
    end else begin
      dst_r     <= dst_nxt;
      cnt_r     <= cnt_nxt;
      rsm_r     <= rsm_nxt;
      sync_n_r  <= sync_n_nxt;
      eos_n_r   <= eos_n_nxt;
      ovld_r    <= ovld_nxt;
      pix_r     <= pix_nxt;
      comp_r    <= comp_nxt;
      hold_r    <= hold_nxt;
      hold_d1_r <= hold_act;
      hold_d2_r <= hold_d1_r;
    end
  end

  assign pixel_o         = pix_r;
  assign pixel_oe        = is_dec;
  assign block_sync_n_o  = sync_n_r;
  assign block_sync_n_oe = is_dec;
  assign scan_end_n_o    = eos_n_r;
  assign scan_end_n_oe   = is_dec;
  assign hold_n_o        = !hold_r;
  assign hold_n_oe       = is_enc;
  assign component_index = comp_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_sync_one_wide: assert property (
    $fell(block_sync_n_o) |=> block_sync_n_o)
    else $error("block sync wider than one cycle");

  a_sync_lead_data: assert property (
    (is_dec && !block_sync_n_o) |=> ovld_r || !is_dec)
    else $error("no sample one cycle after block sync");

  a_bl_low_zero: assert property (
    (is_bl_dec && $past(is_bl_dec) && ovld_r) |-> pixel_o[3:0] == 4'h0)
    else $error("baseline low nibble not zero");

  a_pv_lsb_zero: assert property (
    (mode == ipp_pkg::MODE_PREVIEW && ovld_r) |-> !pixel_o[0])
    else $error("preview lsb not zero");

  a_ll_just_8: assert property (
    (mode == ipp_pkg::MODE_LL_DEC && ovld_r && $past(dec_prec) == 4'h8
     && $past(mode) == ipp_pkg::MODE_LL_DEC)
    |-> pixel_o == {$past(dec_data[7:0]), 4'h0})
    else $error("lossless sample not msb justified");

  a_per_smp_sync: assert property (
    (per_smp && is_dec && $rose(ovld_r)) |-> $past(!block_sync_n_o))
    else $error("sample without preceding block sync");

  a_eos_one_wide: assert property (
    $fell(scan_end_n_o) |=> scan_end_n_o)
    else $error("scan end wider than one cycle");

  a_eos_no_sync: assert property (
    !scan_end_n_o |-> block_sync_n_o ##1 block_sync_n_o)
    else $error("block sync issued with scan end");

  a_eos_bound: assert property (
    (per_smp && is_dec && dec_ready && take_last) |-> ##[1:64] !scan_end_n_o)
    else $error("scan end late after last sample");

  a_bl_blk_step: assert property (
    (is_bl_dec && dst_r == ipp_pkg::DS_DATA && !blk_last && !take_last)
    |=> (dst_r == ipp_pkg::DS_DATA && cnt_r == $past(cnt_r) + 6'h01) || !is_bl_dec)
    else $error("baseline block broke before 64 samples");

  a_hold_lead: assert property (
    (is_bl_enc && hold_mark && enc_full3) |=> !hold_n_o || !is_bl_enc)
    else $error("hold not raised 42 cycles before block end");

  a_hold_release: assert property (
    (is_bl_enc && !enc_full3) |=> hold_n_o)
    else $error("hold kept after buffers drained");

  a_ll_enc_hold: assert property (
    (mode == ipp_pkg::MODE_LL_ENC && enc_full3) |=> !hold_n_o)
    else $error("lossless hold not raised");

  a_enc_first_sync: assert property (
    enc_first |-> !$past(block_sync_n_i, 2))
    else $error("first sample without block sync ahead");

  a_ll_low_zero: assert property (
    (mode == ipp_pkg::MODE_LL_DEC && ovld_r && $past(dec_prec) == 4'h1
     && $past(mode) == ipp_pkg::MODE_LL_DEC) |-> pixel_o[10:0] == 11'h000)
    else $error("lossless unused low bits not zero");

  a_eos_with_smp: assert property (
    !scan_end_n_o |-> ovld_r)
    else $error("scan end without a sample");

  a_wait_no_early: assert property (
    (is_bl_dec && dst_r == ipp_pkg::DS_WAIT && !hold_now && rsm_r != ipp_pkg::RSM_LAST)
    |=> dst_r == ipp_pkg::DS_WAIT || !is_bl_dec)
    else $error("decode resumed before 17 cycles");

endmodule : ipp_top
